//--- rtl/rctrim_regs.vh
// Constants for the RC trim and oscillator configuration block.
// Assumes inclusion by bare name from the rtl/ design files.
`ifndef RCTRIM_REGS_VH
`define RCTRIM_REGS_VH

// Register indices; byte address is four times the index
`define RCT_IDX_TRIM_HI     8'h18
`define RCT_IDX_TRIM_LO     8'h19
`define RCT_IDX_OSC_CFG     8'h1a
`define RCT_IDX_CONFIG_WRITE_LOCK        8'h1b
`define RCT_IDX_CLK_SEL     8'h20
`define RCT_IDX_FLAGS       8'h21
`define RCT_IDX_IRQ_STAT    8'h22
`define RCT_IDX_IRQ_EN      8'h23
`define RCT_IDX_IRQ_CLR     8'h24

// Address decode window
`define RCT_IDX_MSB         9
`define RCT_IDX_LSB         2

// Protection unlock key
`define RCT_CONFIG_WRITE_LOCK_KEY        8'h26

// Trim pair field layout (combined 16-bit view)
`define RCT_TC_MSB          15
`define RCT_TC_LSB          11
`define RCT_FREQ_MSB        9
`define RCT_FREQ_LSB        0
`define RCT_TC_DIR_BIT      4
`define RCT_TC_MAG_MSB      3

// Oscillator configuration fields
`define RCT_OSC_EN_BIT      7

// Own register fields
`define RCT_CLK_PLL_CLOCK_SELECT_BIT  0
`define RCT_FLG_LOCK_BIT    0
`define RCT_FLG_OSC_BIT     1

// Interrupt event positions
`define RCT_EVT_W           4
`define RCT_EVT_LOADED      0
`define RCT_EVT_LOCK        1
`define RCT_EVT_OSC         2
`define RCT_EVT_BLOCKED     3

// Reset values
`define RCT_RST_OSC_CFG     8'h00
`define RCT_RST_LOCK        1'b0
`define RCT_RST_PLL_CLOCK_SELECT      1'b1
`define RCT_RST_TC          5'h00
`define RCT_RST_FREQ        10'h000
`define RCT_TC_NEUTRAL      4'h0

`endif

//--- rtl/rctrim_ahb_slave.v
// AHB-Lite slave front end: address capture, write strobe, wait state.
// Assumes a single master; hready is the bus ready fed back from hreadyout.
`timescale 1ns/10ps
`include "rctrim_regs.vh"

module rctrim_ahb_slave (
   // Clock and reset
   input  wire        hclk,
   input  wire        hresetn,
   // Bus address phase
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire        hready,
   // Bus response
   output wire        hreadyout,
   output wire        hresp,
   // Register side
   output wire        rd_stb,
   output wire        wr_stb,
   output wire [7:0]  wr_idx
);
   reg        wr_ph_q;
   reg        wr_done_q;
   reg        wr_ok_q;
   reg  [7:0] wr_idx_q;
   wire       take;
   wire       aligned;

   assign take    = hsel & hready & htrans[1];
   assign aligned = (haddr[1:0] == 2'b00);

   // One wait state per write so a following read sees the new value
   assign hreadyout = ~(wr_ph_q & ~wr_done_q);
   assign hresp     = 1'b0;
   assign rd_stb    = take & ~hwrite;
   assign wr_stb    = wr_ph_q & ~wr_done_q & wr_ok_q;
   assign wr_idx    = wr_idx_q;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_ph_q   <= 1'b0;
         wr_done_q <= 1'b0;
         wr_ok_q   <= 1'b0;
         wr_idx_q  <= 8'h00;
      end else if (wr_ph_q & ~wr_done_q) begin
         wr_done_q <= 1'b1;
      end else begin
         wr_ph_q   <= take & hwrite;
         wr_done_q <= 1'b0;
         if (take) begin
            wr_ok_q  <= aligned;
            wr_idx_q <= haddr[`RCT_IDX_MSB:`RCT_IDX_LSB];
         end
      end
   end
endmodule // rctrim_ahb_slave

//--- rtl/rctrim_irq.v
// Sticky event status with enable mask and write-one-to-clear.
// Assumes one-cycle event pulses on hclk; set wins over clear.
`timescale 1ns/10ps
`include "rctrim_regs.vh"

module rctrim_irq (
   // Clock and reset
   input  wire                   hclk,
   input  wire                   hresetn,
   // Events and software access
   input  wire [`RCT_EVT_W-1:0]  evt,
   input  wire                   en_we,
   input  wire                   clr_we,
   input  wire [`RCT_EVT_W-1:0]  wdata,
   // State
   output wire [`RCT_EVT_W-1:0]  status,
   output wire [`RCT_EVT_W-1:0]  enable,
   output wire                   irq
);
   reg  [`RCT_EVT_W-1:0] stat_q;
   reg  [`RCT_EVT_W-1:0] en_q;
   reg                   irq_q;
   wire [`RCT_EVT_W-1:0] stat_d;

   assign stat_d = evt | (stat_q & ~(clr_we ? wdata : {`RCT_EVT_W{1'b0}}));
   assign status = stat_q;
   assign enable = en_q;
   assign irq    = irq_q;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stat_q <= {`RCT_EVT_W{1'b0}};
         en_q   <= {`RCT_EVT_W{1'b0}};
         irq_q  <= 1'b0;
      end else begin
         stat_q <= stat_d;
         if (en_we) begin
            en_q <= wdata;
         end
         irq_q  <= |(stat_d & (en_we ? wdata : en_q));
      end
   end
endmodule // rctrim_irq

//--- rtl/rctrim_top.v
// RC reference trim and external oscillator configuration registers.
// Assumes AHB-Lite access on hclk, factory trim word stable at reset release,
// and asynchronous analog lock and stable indications.
//
// Behaviour
// - After reset release, factory trim word loads into both trim registers.
// - Trim registers always readable; writes accepted only while write lock clear.
// - Accepted trim write with PLL select set clears lock and stable flags.
// - Temperature-coefficient trim sits in bits 15..11, high byte at 0x18.
// - Frequency trim in bits 9..0, low byte at 0x19, drives oscillator.
// - Coefficient value zero or top-bit-only disables compensation.
// - Top coefficient bit picks direction, lower four bits the magnitude.
// - Oscillator config always readable; writes need lock clear and PLL select.
// - Each accepted oscillator config write clears lock and stable flags.
// - Protection write of 0x26 clears write lock; other writes set it.
// - Config bit 7 enables external oscillator; stable flag qualifies it.
`timescale 1ns/10ps
`include "rctrim_regs.vh"

module rctrim_top (
   // Clock and reset
   input  wire        hclk,
   input  wire        hresetn,
   // AHB-Lite slave
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output wire        hreadyout,
   output wire        hresp,
   output wire [31:0] hrdata,
   // Factory trim from nonvolatile memory
   input  wire [15:0] nvm_trim_value,
   // Analog status indications
   input  wire        pll_lock_raw,
   input  wire        osc_stable_raw,
   // Reference oscillator trim
   output wire [9:0]  rc_freq_trim,
   output wire [4:0]  temp_coeff_trim,
   output wire        tc_comp_enable,
   output wire        tc_raise,
   output wire [3:0]  tc_magnitude,
   // External oscillator and clock control
   output wire [7:0]  ext_osc_config,
   output wire        ext_osc_enable,
   output wire        ext_osc_pins_claimed,
   output wire        config_write_lock,
   output wire        pll_clock_select,
   output wire        requalify_pulse,
   // Status flags
   output wire        pll_lock_flag,
   output wire        osc_stable_flag,
   // Interrupt
   output wire        irq
);

   // Trim state
   reg  [4:0]  tc_q;
   reg  [4:0]  tc_d;
   reg  [9:0]  freq_q;
   reg  [9:0]  freq_d;
   reg         load_pend_q;

   // Configuration state
   reg  [7:0]  osc_q;
   reg  [7:0]  osc_d;
   reg         lock_q;
   reg         lock_d;
   reg         pll_clock_select_q;
   reg         pll_clock_select_d;
   reg         claimed_q;

   // Flags and synchronisers
   reg         lock_s1_q;
   reg         lock_s2_q;
   reg         lock_s3_q;
   reg         osc_s1_q;
   reg         osc_s2_q;
   reg         osc_s3_q;
   reg         pll_flag_q;
   reg         pll_flag_d;
   reg         osc_flag_q;
   reg         osc_flag_d;
   reg         requal_q;

   // Bus read data
   reg  [31:0] hrdata_q;
   reg  [31:0] rd_mux;

   // Bus front end
   wire        rd_stb;
   wire        wr_stb;
   wire [7:0]  wr_idx;
   wire [7:0]  rd_idx;
   wire [7:0]  wbyte;

   // Decoded writes
   wire        wr_hi;
   wire        wr_lo;
   wire        wr_osc;
   wire        wr_config_write_lock;
   wire        wr_clk;
   wire        wr_ien;
   wire        wr_iclr;
   wire        trim_ok;
   wire        osc_ok;
   wire        flag_clr;
   wire        blocked;
   wire        lock_rise;
   wire        osc_rise;

   // Interrupt unit
   wire [`RCT_EVT_W-1:0] evt;
   wire [`RCT_EVT_W-1:0] irq_stat;
   wire [`RCT_EVT_W-1:0] irq_en;

   // Neutral coefficient codes: magnitude zero in either direction
   function tc_neutral;
      input [4:0] tc;
      begin
         tc_neutral = (tc[`RCT_TC_MAG_MSB:0] == `RCT_TC_NEUTRAL);
      end
   endfunction

   // High byte of the trim pair; bit 10 is not stored
   function [7:0] trim_hi_byte;
      input [4:0] tc;
      input [9:0] freq;
      begin
         trim_hi_byte = {tc, 1'b0, freq[`RCT_FREQ_MSB:8]};
      end
   endfunction

   function idx_is;
      input [7:0] idx;
      input [7:0] target;
      begin
         idx_is = (idx == target);
      end
   endfunction

   rctrim_ahb_slave u_slave (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hready    (hready),
      .hreadyout (hreadyout),
      .hresp     (hresp),
      .rd_stb    (rd_stb),
      .wr_stb    (wr_stb),
      .wr_idx    (wr_idx)
   );

   assign rd_idx = haddr[`RCT_IDX_MSB:`RCT_IDX_LSB];
   assign wbyte  = hwdata[7:0];

   assign wr_hi   = wr_stb & idx_is(wr_idx, `RCT_IDX_TRIM_HI);
   assign wr_lo   = wr_stb & idx_is(wr_idx, `RCT_IDX_TRIM_LO);
   assign wr_osc  = wr_stb & idx_is(wr_idx, `RCT_IDX_OSC_CFG);
   assign wr_config_write_lock = wr_stb & idx_is(wr_idx, `RCT_IDX_CONFIG_WRITE_LOCK);
   assign wr_clk  = wr_stb & idx_is(wr_idx, `RCT_IDX_CLK_SEL);
   assign wr_ien  = wr_stb & idx_is(wr_idx, `RCT_IDX_IRQ_EN);
   assign wr_iclr = wr_stb & idx_is(wr_idx, `RCT_IDX_IRQ_CLR);

   assign trim_ok = ~lock_q;
   assign osc_ok  = ~lock_q & pll_clock_select_q;

   // Only writes that take effect disturb the flags
   assign flag_clr = ((wr_hi | wr_lo) & trim_ok & pll_clock_select_q)
                   | (wr_osc & osc_ok);

   assign blocked = ((wr_hi | wr_lo | wr_clk) & lock_q) | (wr_osc & ~osc_ok);

   assign lock_rise = lock_s2_q & ~lock_s3_q;
   assign osc_rise  = osc_s2_q & ~osc_s3_q;

   // Trim and configuration next state
   always @* begin
      tc_d     = tc_q;
      freq_d   = freq_q;
      osc_d    = osc_q;
      lock_d   = lock_q;
      pll_clock_select_d = pll_clock_select_q;
      if (load_pend_q) begin
         tc_d   = nvm_trim_value[`RCT_TC_MSB:`RCT_TC_LSB];
         freq_d = nvm_trim_value[`RCT_FREQ_MSB:`RCT_FREQ_LSB];
      end else begin
         if (wr_hi & trim_ok) begin
            tc_d         = wbyte[7:3];
            freq_d[9:8]  = wbyte[1:0];
         end
         if (wr_lo & trim_ok) begin
            freq_d[7:0]  = wbyte;
         end
      end
      if (wr_osc & osc_ok) begin
         osc_d = wbyte;
      end
      if (wr_config_write_lock) begin
         lock_d = (wbyte != `RCT_CONFIG_WRITE_LOCK_KEY);
      end
      if (wr_clk & ~lock_q) begin
         pll_clock_select_d = wbyte[`RCT_CLK_PLL_CLOCK_SELECT_BIT];
      end
   end

   // Flags: a rising indication wins over a clear in the same cycle
   always @* begin
      pll_flag_d = pll_flag_q;
      osc_flag_d = osc_flag_q;
      if (lock_rise) begin
         pll_flag_d = 1'b1;
      end else if (flag_clr | ~lock_s2_q) begin
         pll_flag_d = 1'b0;
      end
      if (osc_rise & osc_q[`RCT_OSC_EN_BIT]) begin
         osc_flag_d = 1'b1;
      end else if (flag_clr | ~osc_s2_q | ~osc_q[`RCT_OSC_EN_BIT]) begin
         osc_flag_d = 1'b0;
      end
   end

   // Read multiplexer, sampled in the address phase
   always @* begin
      rd_mux = 32'h0000_0000;
      case (rd_idx)
         `RCT_IDX_TRIM_HI:  rd_mux[7:0] = trim_hi_byte(tc_q, freq_q);
         `RCT_IDX_TRIM_LO:  rd_mux[7:0] = freq_q[7:0];
         `RCT_IDX_OSC_CFG:  rd_mux[7:0] = osc_q;
         `RCT_IDX_CONFIG_WRITE_LOCK:     rd_mux[0]   = lock_q;
         `RCT_IDX_CLK_SEL:  rd_mux[`RCT_CLK_PLL_CLOCK_SELECT_BIT] = pll_clock_select_q;
         `RCT_IDX_FLAGS: begin
            rd_mux[`RCT_FLG_LOCK_BIT] = pll_flag_q;
            rd_mux[`RCT_FLG_OSC_BIT]  = osc_flag_q;
         end
         `RCT_IDX_IRQ_STAT: rd_mux[`RCT_EVT_W-1:0] = irq_stat;
         `RCT_IDX_IRQ_EN:   rd_mux[`RCT_EVT_W-1:0] = irq_en;
         default:           rd_mux = 32'h0000_0000;
      endcase
      if (haddr[1:0] != 2'b00) begin
         rd_mux = 32'h0000_0000;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tc_q        <= `RCT_RST_TC;
         freq_q      <= `RCT_RST_FREQ;
         load_pend_q <= 1'b1;
         osc_q       <= `RCT_RST_OSC_CFG;
         lock_q      <= `RCT_RST_LOCK;
         pll_clock_select_q    <= `RCT_RST_PLL_CLOCK_SELECT;
         claimed_q   <= 1'b0;
         requal_q    <= 1'b0;
         hrdata_q    <= 32'h0000_0000;
      end else begin
         tc_q        <= tc_d;
         freq_q      <= freq_d;
         load_pend_q <= 1'b0;
         osc_q       <= osc_d;
         lock_q      <= lock_d;
         pll_clock_select_q    <= pll_clock_select_d;
         requal_q    <= flag_clr;
         // Pins stay with the oscillator until the next reset
         if (osc_d[`RCT_OSC_EN_BIT]) begin
            claimed_q <= 1'b1;
         end
         if (rd_stb) begin
            hrdata_q <= rd_mux;
         end
      end
   end

   // Analog indications cross into hclk through two flops
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lock_s1_q  <= 1'b0;
         lock_s2_q  <= 1'b0;
         lock_s3_q  <= 1'b0;
         osc_s1_q   <= 1'b0;
         osc_s2_q   <= 1'b0;
         osc_s3_q   <= 1'b0;
         pll_flag_q <= 1'b0;
         osc_flag_q <= 1'b0;
      end else begin
         lock_s1_q  <= pll_lock_raw;
         lock_s2_q  <= lock_s1_q;
         lock_s3_q  <= lock_s2_q;
         osc_s1_q   <= osc_stable_raw;
         osc_s2_q   <= osc_s1_q;
         osc_s3_q   <= osc_s2_q;
         pll_flag_q <= pll_flag_d;
         osc_flag_q <= osc_flag_d;
      end
   end

   assign evt[`RCT_EVT_LOADED]  = load_pend_q;
   assign evt[`RCT_EVT_LOCK]    = pll_flag_d & ~pll_flag_q;
   assign evt[`RCT_EVT_OSC]     = osc_flag_d & ~osc_flag_q;
   assign evt[`RCT_EVT_BLOCKED] = blocked;

   rctrim_irq u_irq (
      .hclk    (hclk),
      .hresetn (hresetn),
      .evt     (evt),
      .en_we   (wr_ien),
      .clr_we  (wr_iclr),
      .wdata   (hwdata[`RCT_EVT_W-1:0]),
      .status  (irq_stat),
      .enable  (irq_en),
      .irq     (irq)
   );

   // Trim outputs to the reference oscillator
   assign rc_freq_trim    = freq_q;
   assign temp_coeff_trim = tc_q;
   assign tc_comp_enable  = ~tc_neutral(tc_q);
   assign tc_raise        = tc_q[`RCT_TC_DIR_BIT];
   assign tc_magnitude    = tc_q[`RCT_TC_MAG_MSB:0];

   // Oscillator and clock control outputs
   assign ext_osc_config       = osc_q;
   assign ext_osc_enable       = osc_q[`RCT_OSC_EN_BIT];
   assign ext_osc_pins_claimed = claimed_q;
   assign config_write_lock    = lock_q;
   assign pll_clock_select     = pll_clock_select_q;
   assign requalify_pulse      = requal_q;
   assign pll_lock_flag        = pll_flag_q;
   assign osc_stable_flag      = osc_flag_q;
   assign hrdata               = hrdata_q;

endmodule // rctrim_top

//--- tb/rctrim_monitor.sv
// Checker for the RC trim and oscillator configuration registers.
// Bound into rctrim_top; sees only its ports, single AHB master on hclk.
`timescale 1ns/10ps
`include "rctrim_regs.vh"

module rctrim_monitor (
   // Clock and reset
   input wire        hclk,
   input wire        hresetn,
   // Bus
   input wire        hsel,
   input wire [31:0] haddr,
   input wire [1:0]  htrans,
   input wire        hwrite,
   input wire [31:0] hwdata,
   input wire        hready,
   input wire        hreadyout,
   // Analog side
   input wire [15:0] nvm_trim_value,
   input wire        pll_lock_raw,
   input wire        osc_stable_raw,
   // Trim and configuration state
   input wire [9:0]  rc_freq_trim,
   input wire [4:0]  temp_coeff_trim,
   input wire        tc_comp_enable,
   input wire        tc_raise,
   input wire [3:0]  tc_magnitude,
   input wire [7:0]  ext_osc_config,
   input wire        ext_osc_enable,
   input wire        ext_osc_pins_claimed,
   input wire        config_write_lock,
   input wire        pll_clock_select,
   input wire        requalify_pulse,
   input wire        pll_lock_flag,
   input wire        osc_stable_flag
);
   reg       wr_q;
   reg [7:0] idx_q;
   reg [5:0] raw_hi_q;
   wire      wr_now = wr_q && !hreadyout;
   wire      trim_w = wr_now && (idx_q == `RCT_IDX_TRIM_HI || idx_q == `RCT_IDX_TRIM_LO);
   wire      osc_w  = wr_now && idx_q == `RCT_IDX_OSC_CFG;

   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // Raw inputs long high: no flag rise can race the clear
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q     <= 1'b0;
         idx_q    <= 8'h00;
         raw_hi_q <= 6'h00;
      end else begin
         raw_hi_q <= {raw_hi_q[4:0], pll_lock_raw & osc_stable_raw};
         if (hready) begin
            wr_q  <= hsel & htrans[1] & hwrite;
            idx_q <= haddr[`RCT_IDX_MSB:`RCT_IDX_LSB];
         end
      end
   end

   a_trim_load: assert property ($rose(hresetn) |=>
      rc_freq_trim == $past(nvm_trim_value[9:0])
      && temp_coeff_trim == $past(nvm_trim_value[15:11])) else $error("trim load wrong");
   a_tc_comp_off: assert property (
      tc_comp_enable == (temp_coeff_trim[3:0] != 4'h0)) else $error("tc compensation wrong");
   a_tc_sign_mag: assert property (
      tc_raise == temp_coeff_trim[4] && tc_magnitude == temp_coeff_trim[3:0])
      else $error("tc direction wrong");
   a_osc_enable_bit: assert property (
      ext_osc_enable == ext_osc_config[`RCT_OSC_EN_BIT]) else $error("osc enable wrong");
   a_pins_sticky: assert property ((ext_osc_enable || $past(ext_osc_pins_claimed))
      |-> ext_osc_pins_claimed) else $error("osc pins released");
   a_config_write_lock_key: assert property (wr_now && idx_q == `RCT_IDX_CONFIG_WRITE_LOCK |=>
      config_write_lock == ($past(hwdata[7:0]) != `RCT_CONFIG_WRITE_LOCK_KEY)) else $error("lock wrong");
   a_trim_locked: assert property (trim_w && config_write_lock |=>
      $stable(rc_freq_trim) && $stable(temp_coeff_trim)) else $error("locked trim changed");
   a_trim_high: assert property (trim_w && !config_write_lock && idx_q == `RCT_IDX_TRIM_HI |=>
      temp_coeff_trim == $past(hwdata[7:3]) && rc_freq_trim[9:8] == $past(hwdata[1:0]))
      else $error("trim high write wrong");
   a_trim_low: assert property (trim_w && !config_write_lock && idx_q == `RCT_IDX_TRIM_LO |=>
      rc_freq_trim[7:0] == $past(hwdata[7:0])) else $error("trim low write wrong");
   a_osc_gate: assert property (osc_w |=> ext_osc_config ==
      (($past(config_write_lock) || !$past(pll_clock_select)) ? $past(ext_osc_config)
      : $past(hwdata[7:0]))) else $error("osc config gating wrong");
   a_flag_clear: assert property ((trim_w || osc_w) && !config_write_lock
      && pll_clock_select && &raw_hi_q |=> !pll_lock_flag && !osc_stable_flag
      && requalify_pulse) else $error("flags not cleared");
endmodule // rctrim_monitor

bind rctrim_top rctrim_monitor u_mon (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
   .hwdata, .hready, .hreadyout, .nvm_trim_value, .pll_lock_raw, .osc_stable_raw,
   .rc_freq_trim, .temp_coeff_trim, .tc_comp_enable, .tc_raise, .tc_magnitude,
   .ext_osc_config, .ext_osc_enable, .ext_osc_pins_claimed, .config_write_lock,
   .pll_clock_select,
   .requalify_pulse, .pll_lock_flag, .osc_stable_flag);

//--- tb/tb_rctrim_top.sv
// Self-checking bench for the RC trim and oscillator configuration block.
// Acts as the only AHB-Lite master; hready is fed back from hreadyout.
`timescale 1ns/10ps
`include "rctrim_regs.vh"

module tb_rctrim_top;
   reg         hclk;
   reg         hresetn;
   reg         hsel;
   reg  [31:0] haddr;
   reg  [1:0]  htrans;
   reg         hwrite;
   reg  [31:0] hwdata;
   reg         pll_lock_raw;
   reg         osc_stable_raw;
   reg  [15:0] nvm_trim;
   wire        hreadyout;
   wire        hresp;
   wire        ext_osc_pins_claimed;
   wire [31:0] hrdata;
   wire [9:0]  rc_freq_trim;
   wire [4:0]  temp_coeff_trim;
   wire        tc_comp_enable;
   wire        tc_raise;
   wire [3:0]  tc_magnitude;
   wire        ext_osc_enable;
   wire        irq;
   integer     n_mismatch;
   integer     n_checks;
   integer     i;

   rctrim_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .nvm_trim_value(nvm_trim), .pll_lock_raw(pll_lock_raw),
      .osc_stable_raw(osc_stable_raw), .rc_freq_trim(rc_freq_trim),
      .temp_coeff_trim(temp_coeff_trim), .tc_comp_enable(tc_comp_enable),
      .tc_raise(tc_raise), .tc_magnitude(tc_magnitude), .ext_osc_config(),
      .ext_osc_enable(ext_osc_enable), .ext_osc_pins_claimed(ext_osc_pins_claimed),
      .config_write_lock(),
      .pll_clock_select(), .requalify_pulse(), .pll_lock_flag(), .osc_stable_flag(),
      .irq(irq));

   always #50 hclk = ~hclk;

   task wrap_up;
      begin
         $display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
         if (n_mismatch == 0 && n_checks > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask

   task chk(input [31:0] got, input [31:0] exp);
      begin
         n_checks = n_checks + 1;
         if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
         end
      end
   endtask

   // Ready looked at before the edge, so the edge that takes it is known
   task wait_rdy(output [31:0] d);
      integer k;
      begin
         k = 0;
         @(negedge hclk);
         while (hreadyout !== 1'b1 && k < 20) begin
            k = k + 1;
            @(negedge hclk);
         end
         if (k >= 20) begin
            n_mismatch = n_mismatch + 1;
            $display("Error at %0t: bus ready timeout", $time);
            wrap_up;
         end
         d = hrdata;
         @(posedge hclk);
      end
   endtask

   task xfer(input w, input [7:0] idx, input [7:0] wd, output [31:0] rdat);
      reg [31:0] unused;
      begin
         hsel   <= 1'b1;
         htrans <= 2'b10;
         hwrite <= w;
         haddr  <= {22'h0, idx, 2'b00};
         wait_rdy(unused);
         hsel   <= 1'b0;
         htrans <= 2'b00;
         hwdata <= {24'h0, wd};
         wait_rdy(rdat);
      end
   endtask

   task wr(input [7:0] idx, input [7:0] wd);
      reg [31:0] unused;
      begin
         xfer(1'b1, idx, wd, unused);
      end
   endtask

   task rd(input [7:0] idx, input [7:0] exp);
      reg [31:0] got;
      begin
         xfer(1'b0, idx, 8'h00, got);
         chk(got, {24'h0, exp});
      end
   endtask

   // A fresh rising edge on both raw indications sets the flags again
   task pulse_raw;
      begin
         pll_lock_raw   <= 1'b0;
         osc_stable_raw <= 1'b0;
         repeat (4) @(posedge hclk);
         pll_lock_raw   <= 1'b1;
         osc_stable_raw <= 1'b1;
         repeat (6) @(posedge hclk);
      end
   endtask

   task chk_irq(input exp);
      begin
         repeat (2) @(posedge hclk);
         @(negedge hclk);
         chk(irq, exp);
         @(posedge hclk);
      end
   endtask

   initial begin
      hclk = 1'b0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hwdata = 32'h0;
      pll_lock_raw = 1'b0;
      osc_stable_raw = 1'b0;
      nvm_trim = 16'hbda5;
      n_mismatch = 0;
      n_checks = 0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      rd(`RCT_IDX_TRIM_HI, 8'hb9);
      rd(`RCT_IDX_TRIM_LO, 8'ha5);
      rd(`RCT_IDX_IRQ_STAT, 8'h01);
      wr(`RCT_IDX_IRQ_CLR, 8'h0f);
      wr(`RCT_IDX_OSC_CFG, 8'h80);
      @(negedge hclk);
      chk(ext_osc_enable, 1'b1);
      @(posedge hclk);
      pulse_raw;
      rd(`RCT_IDX_FLAGS, 8'h03);
      for (i = 0; i < 32; i = i + 1) begin
         wr(`RCT_IDX_TRIM_HI, {i[4:0], 3'b111});
         @(negedge hclk);
         chk(temp_coeff_trim, i[4:0]);
         chk(tc_comp_enable, i[3:0] != 4'h0);
         chk({tc_raise, tc_magnitude}, i[4:0]);
         @(posedge hclk);
         rd(`RCT_IDX_TRIM_HI, {i[4:0], 3'b011});
      end
      rd(`RCT_IDX_FLAGS, 8'h00);
      pulse_raw;
      wr(`RCT_IDX_TRIM_LO, 8'h5a);
      @(negedge hclk);
      chk(rc_freq_trim, 10'h35a);
      @(posedge hclk);
      rd(`RCT_IDX_FLAGS, 8'h00);
      pulse_raw;
      wr(`RCT_IDX_CLK_SEL, 8'h00);
      wr(`RCT_IDX_TRIM_LO, 8'h33);
      wr(`RCT_IDX_OSC_CFG, 8'h00);
      rd(`RCT_IDX_OSC_CFG, 8'h80);
      rd(`RCT_IDX_FLAGS, 8'h03);
      wr(`RCT_IDX_CLK_SEL, 8'h01);
      wr(`RCT_IDX_IRQ_CLR, 8'h0f);
      wr(`RCT_IDX_IRQ_EN, 8'h08);
      wr(`RCT_IDX_CONFIG_WRITE_LOCK, 8'h55);
      rd(`RCT_IDX_CONFIG_WRITE_LOCK, 8'h01);
      wr(`RCT_IDX_TRIM_HI, 8'h00);
      wr(`RCT_IDX_TRIM_LO, 8'h00);
      wr(`RCT_IDX_OSC_CFG, 8'h00);
      rd(`RCT_IDX_TRIM_HI, 8'hfb);
      rd(`RCT_IDX_TRIM_LO, 8'h33);
      rd(`RCT_IDX_OSC_CFG, 8'h80);
      chk_irq(1'b1);
      rd(`RCT_IDX_IRQ_STAT, 8'h08);
      wr(`RCT_IDX_IRQ_EN, 8'h00);
      chk_irq(1'b0);
      wr(`RCT_IDX_IRQ_EN, 8'h08);
      wr(`RCT_IDX_IRQ_CLR, 8'h08);
      chk_irq(1'b0);
      rd(`RCT_IDX_IRQ_STAT, 8'h00);
      wr(`RCT_IDX_CONFIG_WRITE_LOCK, 8'h26);
      rd(`RCT_IDX_CONFIG_WRITE_LOCK, 8'h00);
      wr(`RCT_IDX_TRIM_LO, 8'hc3);
      rd(`RCT_IDX_TRIM_LO, 8'hc3);
      wr(8'h30, 8'hff);
      rd(8'h30, 8'h00);
      rd(`RCT_IDX_IRQ_CLR, 8'h00);
      wr(`RCT_IDX_OSC_CFG, 8'h00);
      @(negedge hclk);
      chk(ext_osc_enable, 1'b0);
      chk(ext_osc_pins_claimed, 1'b1);
      chk(hresp, 1'b0);
      @(posedge hclk);
      // Mid-run reset with a different factory word
      hresetn        <= 1'b0;
      nvm_trim       <= 16'h875a;
      pll_lock_raw   <= 1'b0;
      osc_stable_raw <= 1'b0;
      repeat (2) @(posedge hclk);
      @(negedge hclk);
      chk(ext_osc_pins_claimed, 1'b0);
      @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      @(negedge hclk);
      chk(tc_comp_enable, 1'b0);
      @(posedge hclk);
      rd(`RCT_IDX_TRIM_HI, 8'h83);
      rd(`RCT_IDX_TRIM_LO, 8'h5a);
      rd(`RCT_IDX_CONFIG_WRITE_LOCK, 8'h00);
      rd(`RCT_IDX_IRQ_STAT, 8'h01);
      wrap_up;
   end
endmodule // tb_rctrim_top
